// ### pwr_pkg.sv
`default_nettype none
package pwr_pkg;
  // low-power selection as written by software
  localparam int SEL_W = 2;
  localparam int SEL_IDLE_BIT = 0;
  localparam int SEL_PDN_BIT = 1;
  localparam logic [1:0] SEL_RESET = 2'h0;

  typedef enum logic [2:0] {
    ST_RUN    = 3'b000,
    ST_HALT   = 3'b001,
    ST_IDLE   = 3'b010,
    ST_SERV   = 3'b011,
    ST_PDN    = 3'b100
  } pwr_state_t;

  // wake and service requests, asynchronous until the input synchronisers
  typedef struct packed {
    logic nmi;
    logic irq_unmasked;
    logic refresh_req;
    logic hold_req;
  } wake_t;

  // clock gate controls
  typedef struct packed {
    logic core_en;
    logic periph_en;
    logic osc_en;
  } clk_ctl_t;

  localparam clk_ctl_t CLK_ALL_ON = 3'h7;
endpackage
`default_nettype wire

// ### idle_powerdown_control.sv
`timescale 1ns/100ps
`default_nettype none
module idle_powerdown_control (
  // clock and reset
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  // software control
  input wire logic [pwr_pkg::SEL_W-1:0] SEL_IN,
  input wire logic SEL_WR_IN,
  input wire logic HALT_IN,
  // wake sources, asynchronous
  input wire pwr_pkg::wake_t WAKE_IN,
  // service completion from the bus unit
  input wire logic SERV_DONE_IN,
  // clock controls, state and control bits
  output var pwr_pkg::clk_ctl_t CLK_CTL_OUT,
  output var pwr_pkg::pwr_state_t STATE_OUT,
  output logic [pwr_pkg::SEL_W-1:0] SEL_OUT
);
  import pwr_pkg::*;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  // nmi restarts from powerdown, so this clock must be the free-running
  // wake clock; the oscillator enable only gates the distributed clocks
  wake_t s1_reg, s2_reg, s3_reg, wake_reg;

  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= WAKE_IN;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      wake_reg <= '0;
    end else begin
      for (int i = 0; i < $bits(wake_t); i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          wake_reg[i] <= s3_reg[i];
        end
      end
    end
  end

  // ----------------------------------------
  // control bits
  // ----------------------------------------
  logic [SEL_W-1:0] sel_reg;

  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      sel_reg <= SEL_RESET;
    end else if (SEL_WR_IN) begin
      sel_reg <= SEL_IN;
    end
  end

  // ----------------------------------------
  // state machine
  // ----------------------------------------
  pwr_state_t state_reg, state_next;
  logic serv_req;
  logic core_wake;

  assign serv_req = wake_reg.refresh_req | wake_reg.hold_req;
  assign core_wake = wake_reg.nmi | wake_reg.irq_unmasked;

  // completion may come before the request has cleared the synchronisers;
  // remember it, else the return to idle would be missed for good
  logic done_seen_reg;

  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      done_seen_reg <= 1'b0;
    end else if (state_reg == ST_SERV && SERV_DONE_IN) begin
      done_seen_reg <= 1'b1;
    end else if (state_reg != ST_SERV) begin
      done_seen_reg <= 1'b0;
    end
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_RUN: begin
        if (HALT_IN) begin
          if (sel_reg[SEL_PDN_BIT]) begin
            state_next = ST_PDN;
          end else if (sel_reg[SEL_IDLE_BIT]) begin
            state_next = ST_IDLE;
          end else begin
            state_next = ST_HALT;
          end
        end
      end
      ST_HALT: begin
        if (core_wake) begin
          state_next = ST_RUN;
        end
      end
      ST_IDLE: begin
        if (core_wake) begin
          state_next = ST_RUN;
        end else if (serv_req) begin
          state_next = ST_SERV;
        end
      end
      ST_SERV: begin
        if (core_wake) begin
          state_next = ST_RUN;
        end else if ((SERV_DONE_IN || done_seen_reg) && !serv_req) begin
          state_next = ST_IDLE;
        end
      end
      ST_PDN: begin
        if (wake_reg.nmi) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  // reset restarts from any state
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      state_reg <= ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // clock gating
  // ----------------------------------------
  // registered so the gate enables never glitch; core state itself lives in
  // the gated domain and simply holds while its clock is off
  clk_ctl_t ctl_reg;

  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      ctl_reg <= CLK_ALL_ON;
    end else begin
      ctl_reg <= CLK_ALL_ON;
      unique case (state_next)
        ST_IDLE: ctl_reg.core_en <= 1'b0;
        ST_PDN: ctl_reg <= '0;
        ST_RUN, ST_HALT, ST_SERV: ctl_reg <= CLK_ALL_ON;
        default: ctl_reg <= CLK_ALL_ON;
      endcase
    end
  end

  assign CLK_CTL_OUT = ctl_reg;
  assign STATE_OUT = state_reg;
  assign SEL_OUT = sel_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_idle_core_off: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (state_reg == ST_IDLE) |-> (!ctl_reg.core_en && ctl_reg.periph_en && ctl_reg.osc_en))
    else $error("idle clock gating wrong");
  a_idle_irq_wake: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (state_reg == ST_IDLE && wake_reg.irq_unmasked) |=> (state_reg == ST_RUN && ctl_reg.core_en))
    else $error("idle did not wake on interrupt");
  a_serv_return: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (state_reg == ST_SERV && SERV_DONE_IN && !serv_req && !core_wake) |=> (state_reg == ST_IDLE))
    else $error("service did not return to idle");
  a_serv_core_on: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (state_reg == ST_IDLE && serv_req && !core_wake) |=> (state_reg == ST_SERV && ctl_reg.core_en))
    else $error("service did not wake core");
  a_pdn_all_off: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (state_reg == ST_PDN) |-> (ctl_reg == '0))
    else $error("powerdown clocks not off");
  a_pdn_irq_ignored: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (state_reg == ST_PDN && !wake_reg.nmi) |=> (state_reg == ST_PDN))
    else $error("powerdown left without nmi");
  a_entry_needs_halt: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (state_reg == ST_RUN && !HALT_IN) |=> (state_reg == ST_RUN))
    else $error("low-power entry without halt");
  a_plain_halt: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (state_reg == ST_RUN && HALT_IN && sel_reg == '0) |=> (state_reg == ST_HALT) ##1 (ctl_reg == CLK_ALL_ON))
    else $error("plain halt gated clocks");
  a_state_held: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (state_reg == ST_PDN && !SEL_WR_IN) |=> $stable(sel_reg))
    else $error("control lost in powerdown");
  a_pdn_nmi_wake: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (state_reg == ST_PDN && wake_reg.nmi) |=> (state_reg == ST_RUN && ctl_reg == CLK_ALL_ON))
    else $error("powerdown did not wake on nmi");
  a_halt_wake: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (state_reg == ST_HALT && core_wake) |=> (state_reg == ST_RUN && ctl_reg == CLK_ALL_ON))
    else $error("plain halt did not wake");
  a_halt_hold: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (state_reg == ST_HALT && !core_wake) |=> (state_reg == ST_HALT && ctl_reg == CLK_ALL_ON))
    else $error("plain halt left or gated");
  a_idle_stays: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (state_reg == ST_IDLE && !core_wake && !serv_req) |=> (state_reg == ST_IDLE))
    else $error("idle left without a wake source");
  a_serv_holds: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (state_reg == ST_SERV && !core_wake && !SERV_DONE_IN && !done_seen_reg)
      |=> (state_reg == ST_SERV && ctl_reg.core_en))
    else $error("service ended before completion");
  a_reset_restart: assert property (@(posedge MCLK_IN)
    RST_IN |=> (state_reg == ST_RUN && ctl_reg == CLK_ALL_ON && sel_reg == SEL_RESET))
    else $error("reset did not restart");
  a_pdn_entry: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (state_reg == ST_RUN && HALT_IN && sel_reg[SEL_PDN_BIT]) |=> (state_reg == ST_PDN && ctl_reg == '0))
    else $error("powerdown not entered on halt");
  a_idle_entry: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (state_reg == ST_RUN && HALT_IN && sel_reg[SEL_IDLE_BIT] && !sel_reg[SEL_PDN_BIT]) |=> (state_reg == ST_IDLE))
    else $error("idle not entered on halt");
endmodule // idle_powerdown_control
`default_nettype wire

// ### tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import pwr_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, sel_wr = 1'b0, halt = 1'b0, done = 1'b0;
  logic [SEL_W-1:0] sel = 2'h0, sel_q;
  logic [31:0] seed = 32'h00005897;
  wake_t wake = '0;
  clk_ctl_t clk_ctl;
  pwr_state_t state;
  pwr_state_t exp_q[$];
  int fail_count = 0, check_count = 0;
  always #10 mclk = ~mclk;
  idle_powerdown_control dut (.MCLK_IN(mclk), .RST_IN(rst), .SEL_IN(sel), .SEL_WR_IN(sel_wr),
    .HALT_IN(halt), .WAKE_IN(wake), .SERV_DONE_IN(done), .CLK_CTL_OUT(clk_ctl), .STATE_OUT(state),
    .SEL_OUT(sel_q));
  // ----------------------------------------
  // model and helpers
  // ----------------------------------------
  function automatic clk_ctl_t exp_clk(pwr_state_t s);
    if (s == ST_IDLE) return 3'h3;
    if (s == ST_PDN) return 3'h0;
    return 3'h7;
  endfunction
  function automatic logic [31:0] xorshift(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic step(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // wake paths pass synchronisers, so allow a bounded wait
  task automatic expect_st(pwr_state_t s, int n);
    for (int i = 0; i < n && state !== s; i++) step(1);
    chk(8'(state), 8'(s));
    chk(8'(clk_ctl), 8'(exp_clk(s)));
  endtask
  task automatic go(logic [SEL_W-1:0] v);
    sel = v;
    sel_wr = 1'b1;
    step(1);
    sel_wr = 1'b0;
    halt = 1'b1;
    step(1);
    halt = 1'b0;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    give_verdict;
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    step(20);
    rst = 1'b0;
    expect_st(ST_RUN, 1);
    chk(8'(sel_q), 8'(SEL_RESET));
    sel = 2'h1;
    sel_wr = 1'b1;
    step(1);
    sel_wr = 1'b0;
    step(3);
    expect_st(ST_RUN, 1);
    go(2'h1);
    expect_st(ST_IDLE, 1);
    halt = 1'b1;
    step(1);
    halt = 1'b0;
    expect_st(ST_IDLE, 1);
    wake.refresh_req = 1'b1;
    expect_st(ST_SERV, 12);
    wake.refresh_req = 1'b0;
    step(6);
    done = 1'b1;
    step(1);
    done = 1'b0;
    expect_st(ST_IDLE, 2);
    // completion reported while the request is still up
    wake.refresh_req = 1'b1;
    expect_st(ST_SERV, 12);
    done = 1'b1;
    step(1);
    done = 1'b0;
    wake.refresh_req = 1'b0;
    expect_st(ST_SERV, 1);
    expect_st(ST_IDLE, 12);
    wake.irq_unmasked = 1'b1;
    expect_st(ST_RUN, 12);
    wake = '0;
    step(6);
    go(2'h1);
    expect_st(ST_IDLE, 1);
    wake.hold_req = 1'b1;
    expect_st(ST_SERV, 12);
    wake.hold_req = 1'b0;
    wake.irq_unmasked = 1'b1;
    expect_st(ST_RUN, 12);
    wake = '0;
    step(6);
    go(2'h0);
    expect_st(ST_HALT, 1);
    wake.refresh_req = 1'b1;
    step(8);
    expect_st(ST_HALT, 1);
    wake.irq_unmasked = 1'b1;
    expect_st(ST_RUN, 12);
    wake = '0;
    step(6);
    go(2'h2);
    expect_st(ST_PDN, 1);
    wake = 4'h7;
    step(12);
    expect_st(ST_PDN, 1);
    chk(8'(sel_q), 8'h2);
    wake = '0;
    step(6);
    go(2'h1);
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    expect_st(ST_RUN, 1);
    chk(8'(sel_q), 8'(SEL_RESET));
    for (int i = 0; i < 8; i++) begin
      seed = xorshift(seed);
      exp_q.push_back(seed[1] ? ST_PDN : seed[0] ? ST_IDLE : ST_HALT);
      go(seed[1:0]);
      chk(8'(sel_q), 8'(seed[1:0]));
      expect_st(exp_q.pop_front(), 1);
      wake.nmi = 1'b1;
      expect_st(ST_RUN, 12);
      wake = '0;
      step(6);
    end
    give_verdict;
  end
endmodule // tb
`default_nettype wire
